// >>> verilog/sdcr_defs.svh
`ifndef SDCR_DEFS_SVH
`define SDCR_DEFS_SVH
`define SDCR_OFS_C0_LIMSLEW 8'h03
`define SDCR_OFS_C1_MODEEN 8'h04
`define SDCR_OFS_C1_LIMSLEW 8'h05
`define SDCR_OFS_C0_LEVEL 8'h06
`define SDCR_RST_LIMSLEW 8'h1A
`define SDCR_RST_MODEEN 8'h08
`define SDCR_RST_LEVEL 8'h00
`define SDCR_LIMSLEW_MASK 8'h3F
`define SDCR_MODEEN_MASK 8'h1F
`define SDCR_ILIM_MSB 5
`define SDCR_ILIM_LSB 3
`define SDCR_SLEW_MSB 2
`define SDCR_SLEW_LSB 0
`define SDCR_FPWM_BIT 4
`define SDCR_RDIS_BIT 3
`define SDCR_ENSRC_MSB 2
`define SDCR_ENSRC_LSB 1
`define SDCR_ON_BIT 0
`define SDCR_ILIM_RESERVED 3'h7
`define SDCR_SLEW_MIN 3'h2
`define SDCR_VSET_MIN 8'h14
`endif

// >>> verilog/sdcr_pkg.sv
package sdcr_pkg;
    typedef logic [7:0] sdcr_byte_t;
    typedef enum logic [1:0] {
        SDCR_SRC_BIT_ONLY = 2'h0,
        SDCR_SRC_PIN_A = 2'h1,
        SDCR_SRC_PIN_B = 2'h2,
        SDCR_SRC_PIN_C = 2'h3
    } sdcr_src_e;
endpackage

// >>> verilog/sdcr_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser; output moves only when stages two and three agree
module sdcr_pin_sync (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;
    wire agree = (s2 == s3);
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (agree) begin
                level_o <= s3;
            end
        end
    end
endmodule // sdcr_pin_sync
`default_nettype wire

// >>> verilog/sdcr_regs.sv
// Notes on behaviour
// - limit code 0..6 gives 1.5..4.5 A
// - new limit code applies immediately, even running
// - slew codes 2..7 valid, 0,1 reserved
// - slew applies to rising and falling ramps
// - mode bit one forces fixed switching
// - discharge bit connects resistor while off
// - enable source selects optional pin gating
// - enable bit turns converter on
// - reset values 0x1A and 0x08
// - defaults load from programmable memory, discharge fixed
// - voltage code register at 6 resets zero
// - voltage code table 0x14..0xFF valid
`timescale 1ns/100ps
`default_nettype none
`include "sdcr_defs.svh"
module sdcr_regs
    import sdcr_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] dflt_c0_limslew_i,
    input wire logic [7:0] dflt_c1_modeen_i,
    input wire logic [7:0] dflt_c1_limslew_i,
    input wire logic [7:0] dflt_c0_level_i,
    input wire logic dflt_load_i,
    input wire logic enable_pin_a_i,
    input wire logic enable_pin_b_i,
    input wire logic enable_pin_c_i,
    output logic [2:0] conv0_peak_current_limit_o,
    output logic [2:0] conv0_ramp_speed_o,
    output logic [2:0] conv1_peak_current_limit_o,
    output logic [2:0] conv1_ramp_speed_o,
    output logic conv1_force_fixed_switching_o,
    output logic conv1_discharge_active_o,
    output logic conv1_run_o,
    output logic [7:0] conv0_voltage_code_o,
    output logic code_reserved_o
);
    sdcr_byte_t conv0_limit_slew;
    sdcr_byte_t conv1_mode_enable;
    sdcr_byte_t conv1_limit_slew;
    sdcr_byte_t conv0_output_level;
    logic pin_a;
    logic pin_b;
    logic pin_c;

    sdcr_pin_sync u_sync_a (.clock_i(clock_i), .rst_i(rst_i), .pin_i(enable_pin_a_i),
        .level_o(pin_a));
    sdcr_pin_sync u_sync_b (.clock_i(clock_i), .rst_i(rst_i), .pin_i(enable_pin_b_i),
        .level_o(pin_b));
    sdcr_pin_sync u_sync_c (.clock_i(clock_i), .rst_i(rst_i), .pin_i(enable_pin_c_i),
        .level_o(pin_c));

    // reserved field codes the converter cannot honour
    function automatic logic bad_limslew(input sdcr_byte_t v);
        bad_limslew = (v[`SDCR_ILIM_MSB:`SDCR_ILIM_LSB] == `SDCR_ILIM_RESERVED)
            || (v[`SDCR_SLEW_MSB:`SDCR_SLEW_LSB] < `SDCR_SLEW_MIN);
    endfunction

    wire sel_c0_ls = (addr_i == `SDCR_OFS_C0_LIMSLEW);
    wire sel_c1_me = (addr_i == `SDCR_OFS_C1_MODEEN);
    wire sel_c1_ls = (addr_i == `SDCR_OFS_C1_LIMSLEW);
    wire sel_c0_lv = (addr_i == `SDCR_OFS_C0_LEVEL);
    wire wr_c0_ls = wr_i && sel_c0_ls;
    wire wr_c1_me = wr_i && sel_c1_me;
    wire wr_c1_ls = wr_i && sel_c1_ls;
    wire wr_c0_lv = wr_i && sel_c0_lv;

    // discharge bit keeps its fixed reset value on a default load
    wire [7:0] dflt_me = (dflt_c1_modeen_i & ~(8'h01 << `SDCR_RDIS_BIT))
        | (`SDCR_RST_MODEEN & (8'h01 << `SDCR_RDIS_BIT));

    wire [7:0] rd_mux = sel_c0_ls ? conv0_limit_slew :
                        sel_c1_me ? conv1_mode_enable :
                        sel_c1_ls ? conv1_limit_slew :
                        sel_c0_lv ? conv0_output_level : 8'h00;

    wire sdcr_src_e src = sdcr_src_e'(conv1_mode_enable[`SDCR_ENSRC_MSB:`SDCR_ENSRC_LSB]);
    logic gate_ok;
    always_comb begin
        unique case (src)
            SDCR_SRC_BIT_ONLY: gate_ok = 1'b1;
            SDCR_SRC_PIN_A: gate_ok = pin_a;
            SDCR_SRC_PIN_B: gate_ok = pin_b;
            SDCR_SRC_PIN_C: gate_ok = pin_c;
        endcase
    end
    wire next_run = conv1_mode_enable[`SDCR_ON_BIT] && gate_ok;
    wire next_dis = !next_run && conv1_mode_enable[`SDCR_RDIS_BIT];
    wire next_bad = bad_limslew(conv0_limit_slew) || bad_limslew(conv1_limit_slew)
        || (conv0_output_level < `SDCR_VSET_MIN);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            conv0_limit_slew <= `SDCR_RST_LIMSLEW;
            conv1_mode_enable <= `SDCR_RST_MODEEN;
            conv1_limit_slew <= `SDCR_RST_LIMSLEW;
            conv0_output_level <= `SDCR_RST_LEVEL;
        end else if (dflt_load_i) begin
            conv0_limit_slew <= dflt_c0_limslew_i & `SDCR_LIMSLEW_MASK;
            conv1_mode_enable <= dflt_me & `SDCR_MODEEN_MASK;
            conv1_limit_slew <= dflt_c1_limslew_i & `SDCR_LIMSLEW_MASK;
            conv0_output_level <= dflt_c0_level_i;
        end else begin
            // writes take effect at once, running or not
            if (wr_c0_ls) begin
                conv0_limit_slew <= wdata_i & `SDCR_LIMSLEW_MASK;
            end
            if (wr_c1_me) begin
                conv1_mode_enable <= wdata_i & `SDCR_MODEEN_MASK;
            end
            if (wr_c1_ls) begin
                conv1_limit_slew <= wdata_i & `SDCR_LIMSLEW_MASK;
            end
            if (wr_c0_lv) begin
                conv0_output_level <= wdata_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            conv0_peak_current_limit_o <= 3'h0;
            conv0_ramp_speed_o <= 3'h0;
            conv1_peak_current_limit_o <= 3'h0;
            conv1_ramp_speed_o <= 3'h0;
            conv1_force_fixed_switching_o <= 1'b0;
            conv1_discharge_active_o <= 1'b0;
            conv1_run_o <= 1'b0;
            conv0_voltage_code_o <= 8'h00;
            code_reserved_o <= 1'b0;
        end else begin
            conv0_peak_current_limit_o <= conv0_limit_slew[`SDCR_ILIM_MSB:`SDCR_ILIM_LSB];
            conv0_ramp_speed_o <= conv0_limit_slew[`SDCR_SLEW_MSB:`SDCR_SLEW_LSB];
            conv1_peak_current_limit_o <= conv1_limit_slew[`SDCR_ILIM_MSB:`SDCR_ILIM_LSB];
            conv1_ramp_speed_o <= conv1_limit_slew[`SDCR_SLEW_MSB:`SDCR_SLEW_LSB];
            conv1_force_fixed_switching_o <= conv1_mode_enable[`SDCR_FPWM_BIT];
            conv1_discharge_active_o <= next_dis;
            conv1_run_o <= next_run;
            conv0_voltage_code_o <= conv0_output_level;
            code_reserved_o <= next_bad;
        end
    end

    a_limit_follows: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_c0_ls && !dflt_load_i |-> ##2 conv0_peak_current_limit_o == $past(wdata_i[5:3], 2))
        else $error("limit code not applied two cycles after write");
    a_slew_follows: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_c1_ls && !dflt_load_i |-> ##2 conv1_ramp_speed_o == $past(wdata_i[2:0], 2))
        else $error("slew code not applied");
    a_mode_follows: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_c1_me && !dflt_load_i |-> ##2 conv1_force_fixed_switching_o == $past(wdata_i[4], 2))
        else $error("mode bit not applied");
    a_run_gated: assert property (@(posedge clock_i) disable iff (rst_i)
        conv1_run_o |-> $past(conv1_mode_enable[0]))
        else $error("converter runs without enable bit");
    a_run_pin_a: assert property (@(posedge clock_i) disable iff (rst_i)
        conv1_run_o && $past(conv1_mode_enable[2:1]) == 2'h1 |-> $past(pin_a))
        else $error("pin a gating ignored");
    a_discharge_off: assert property (@(posedge clock_i) disable iff (rst_i)
        conv1_discharge_active_o |-> !conv1_run_o)
        else $error("discharge while running");
    a_reset_vals: assert property (@(posedge clock_i)
        $past(rst_i) && rst_i |-> conv0_limit_slew == 8'h1A && conv1_mode_enable == 8'h08)
        else $error("wrong reset value");
    a_level_reset: assert property (@(posedge clock_i)
        $past(rst_i) && rst_i |-> conv0_output_level == 8'h00)
        else $error("voltage code not zero at reset");
    a_read_data: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_i && sel_c0_lv && !wr_i |=> rdata_o == $past(conv0_output_level))
        else $error("voltage code readback wrong");
    a_dflt_rdis: assert property (@(posedge clock_i) disable iff (rst_i)
        dflt_load_i |=> conv1_mode_enable[3])
        else $error("discharge bit took programmed default");

    c_write_limit: cover property (@(posedge clock_i) disable iff (rst_i) wr_c0_ls);
    c_run_pin: cover property (@(posedge clock_i) disable iff (rst_i)
        conv1_run_o && conv1_mode_enable[2:1] != 2'h0);
    c_discharge: cover property (@(posedge clock_i) disable iff (rst_i) conv1_discharge_active_o);
    c_reserved: cover property (@(posedge clock_i) disable iff (rst_i) code_reserved_o);
endmodule // sdcr_regs
`default_nettype wire

// >>> tb/step_down_control_registers_bench.sv
`timescale 1ns/100ps
`default_nettype none
module step_down_control_registers_bench;
    import sdcr_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_d = 1'b0;
    logic dflt_load_i = 1'b0;
    logic [7:0] dflt [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0] pin = 3'h0;
    logic [7:0] rdata_o, vcode, want;
    logic [2:0] lim0, spd0, lim1, spd1;
    logic fixed, disch, run, resv;
    logic [7:0] exp_q [$];
    logic [7:0] v;
    logic [7:0] tbl [8][3];
    int num_errors = 0;
    int checked = 0;
    sdcr_regs u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dflt_c0_limslew_i(dflt[0]),
        .dflt_c1_modeen_i(dflt[1]), .dflt_c1_limslew_i(dflt[2]), .dflt_c0_level_i(dflt[3]),
        .dflt_load_i(dflt_load_i), .enable_pin_a_i(pin[0]), .enable_pin_b_i(pin[1]),
        .enable_pin_c_i(pin[2]), .conv0_peak_current_limit_o(lim0), .conv0_ramp_speed_o(spd0),
        .conv1_peak_current_limit_o(lim1), .conv1_ramp_speed_o(spd1),
        .conv1_force_fixed_switching_o(fixed), .conv1_discharge_active_o(disch),
        .conv1_run_o(run), .conv0_voltage_code_o(vcode), .code_reserved_o(resv));
    always #2 clock_i = ~clock_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        exp_q.push_back(exp);
    endtask
    // drop the strobes, wait, then sample once the edge updates have landed
    task automatic settle(input int n);
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clock_i) begin
        rd_d <= rd_i;
        if (rd_d) begin
            want = exp_q.pop_front();
            chk(rdata_o, want);
        end
    end
    initial begin
        #20000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h5b04));
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        settle(0);
        chk({lim0, spd0}, 8'h1A);
        chk(resv, 8'h01);
        for (int i = 0; i < 4; i++) rd_reg(i == 0 ? 8'h03 : i == 1 ? 8'h04 : i == 2 ? 8'h05 : 8'h06,
            i == 1 ? 8'h08 : i == 3 ? 8'h00 : 8'h1A);
        rd_reg(8'h07, 8'h00);
        settle(2);
        $display("reset values done");
        v = $urandom;
        wr_reg(8'h03, v);
        wr_reg(8'h04, v);
        wr_reg(8'h06, v);
        wr_reg(8'h07, ~v);
        rd_reg(8'h03, v & 8'h3F);
        rd_reg(8'h04, v & 8'h1F);
        rd_reg(8'h06, v);
        rd_reg(8'h07, 8'h00);
        rd_reg(8'h02, 8'h00);
        settle(2);
        chk(vcode, v);
        $display("access kinds done");
        wr_reg(8'h04, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h05, {2'h0, i[2:0], ~i[2:0]});
            wr_reg(8'h03, {2'h0, ~i[2:0], i[2:0]});
            settle(2);
            chk({lim1, spd1}, {2'h0, i[2:0], ~i[2:0]});
            chk({lim0, spd0}, {2'h0, ~i[2:0], i[2:0]});
            chk(run, 8'h01);
        end
        $display("limit and slew codes done");
        for (int i = 0; i < 16; i++) begin
            v = $urandom & 8'h1F;
            pin <= $urandom;
            wr_reg(8'h04, {v[7:3], i[1:0], v[0]});
            settle(10);
            want = v[0] & (i[1:0] == 2'h0 ? 1'b1 : pin[i[1:0] - 2'h1]);
            chk(run, want);
            chk(disch, v[3] & ~want[0]);
            chk(fixed, v[4]);
        end
        $display("enable gating done");
        wr_reg(8'h04, 8'h08);
        foreach (dflt[i]) dflt[i] <= $urandom & (i == 3 ? 8'hFF : i == 1 ? 8'h17 : 8'h3F);
        wr_reg(8'h06, 8'h55);
        dflt_load_i <= 1'b1;
        settle(0);
        dflt_load_i <= 1'b0;
        rd_reg(8'h03, dflt[0]);
        rd_reg(8'h04, dflt[1] | 8'h08);
        rd_reg(8'h05, dflt[2]);
        rd_reg(8'h06, dflt[3]);
        settle(2);
        $display("default load done");
        tbl = '{'{8'h03, 8'h1A, 8'h00}, '{8'h05, 8'h1A, 8'h00}, '{8'h06, 8'h13, 8'h01},
            '{8'h06, 8'h14, 8'h00}, '{8'h06, 8'hFF, 8'h00}, '{8'h03, 8'h3A, 8'h01},
            '{8'h03, 8'h1A, 8'h00}, '{8'h05, 8'h19, 8'h01}};
        foreach (tbl[i]) begin
            wr_reg(tbl[i][0], tbl[i][1]);
            settle(2);
            if (i > 1) chk(resv, tbl[i][2]);
            if (tbl[i][0] == 8'h06) chk(vcode, tbl[i][1]);
        end
        rd_reg(8'h05, 8'h19);
        settle(2);
        $display("reserved codes done");
        report_and_stop();
    end
endmodule // step_down_control_registers_bench
`default_nettype wire
